/* common/sspc_pkg.sv */
/*
  package for the stop/standby power controller: register map, field
  positions, reset values, timing constants, modes and carriers.
  assumes a 32-bit axi4-lite register bus and a 100 MHz system clock.
*/
`default_nettype none
package sspc_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] SSPC_OFS_CTRL = 8'h00;   // power_mode_control
  localparam logic [7:0] SSPC_OFS_STAT = 8'h04;   // power_status_reg
  localparam logic [7:0] SSPC_OFS_BKDC = 8'h08;   // backup_domain_control copy
  // power_mode_control fields
  localparam int SSPC_CTRL_REGULATOR_LOWPOWER_IN_STOP = 0;
  localparam int SSPC_CTRL_POWERDOWN_ON_DEEPSLEEP = 1;
  localparam int SSPC_CTRL_CLEAR_WAKEUP_FLAG_CMD = 2;
  localparam int SSPC_CTRL_CLEAR_STANDBY_FLAG_CMD = 3;
  localparam int SSPC_CTRL_DBP = 8;
  // power_status_reg fields
  localparam int SSPC_STAT_WUF = 0;
  localparam int SSPC_STAT_SBF = 1;
  localparam int SSPC_STAT_WAKEUP_PIN_ENABLE = 8;
  // backup_domain_control fields
  localparam int SSPC_BKDC_LOW_SPEED_CRYSTAL_ON = 0;
  localparam int SSPC_BKDC_RTCSEL = 8;
  localparam int SSPC_BKDC_RTC_CLOCK_ENABLE = 15;
  localparam logic [31:0] SSPC_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] SSPC_STAT_RESET = 32'h0000_0000;
  // ==========================================================
  // timing
  localparam int SSPC_CLK_MHZ = 100;
  localparam int SSPC_CLEAR_WAKEUP_FLAG_CMD_DELAY = 2;        // cycles from write to clear
  localparam int SSPC_HSI_START_NS = 2000;   // oscillator start-up, ns
  localparam int SSPC_HSI_START_CYC = (SSPC_HSI_START_NS * SSPC_CLK_MHZ + 999) / 1000;
  localparam int SSPC_RESET_PHASE_NS = 1000; // reset phase after standby, ns
  localparam int SSPC_RESET_PHASE_CYC = (SSPC_RESET_PHASE_NS * SSPC_CLK_MHZ + 999) / 1000;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    SSPC_RUN, SSPC_STOP_WAIT, SSPC_STOP, SSPC_STOP_WAKE, SSPC_STBY, SSPC_STBY_RST
  } sspc_state_e;
  typedef struct packed {
    logic core_clk_en;
    logic pll_en;
    logic hsi_en;
    logic hse_en;
    logic reg_on;
    logic reg_lowpower;
    logic io_freeze;
    logic io_hiz;
    logic hsi_sysclk_sel;
  } sspc_pwr_s;
  typedef struct packed {
    logic rtc_en;
    logic lse_on;
    logic [1:0] rtc_src;
  } sspc_bkd_s;
endpackage
`default_nettype wire

/* src/sspc_ctrl.sv */
/*
  stop/standby power controller: axi4-lite registers, deep-sleep entry
  decision, stop and standby sequencing, wakeup and flag handling.
  assumes the core raises deep_sleep_req for one cycle per wfi/wfe,
  and that pending, busy and wakeup inputs are synchronous to aclk.
*/
// Functional notes
// RULE1: stop gates core clocks, pll, oscillators
// RULE2: stop freezes all io pins
// RULE3: stop waits for flash programming
// RULE4: stop waits for peripheral bus transfer
// RULE5: started watchdog runs until reset
// RULE6: rtc and lse follow backup control bits
// RULE7: stop exit selects internal rc clock
// RULE8: deepsleep without powerdown bit enters stop
// RULE9: pending interrupts or alarm cancel entry
// RULE10: wfi wakes on irq, wfe on event
// RULE11: standby powers off regulator and oscillators
// RULE12: standby exit on reset, watchdog, alarm, pin
// RULE13: standby exit performs full reset phase
// RULE14: standby flag reports standby after wake
// RULE15: standby needs powerdown bit, clear wakeup flag
// RULE16: standby tristates io except kept pins
// RULE17: rtc source select for auto wakeup
// RULE18: backup write unlock gates rtc writes
// RULE19: standby clear command reads zero, clears
// RULE20: wakeup clear acts two cycles later
// RULE21: powerdown bit picks stop or standby
// RULE22: lowpower bit sets regulator mode in stop
// RULE23: pin or alarm sets wakeup flag
// RULE24: wakeup pin enable selects pull-down input
// RULE25: standby flag cleared only by por or command
// RULE26: mode bits sampled with the request
`timescale 1ns/1ps
`default_nettype none
module sspc_ctrl
  import sspc_pkg::*;
#(
  parameter int HSI_START_CYC = sspc_pkg::SSPC_HSI_START_CYC,
  parameter int RESET_PHASE_CYC = sspc_pkg::SSPC_RESET_PHASE_CYC
) (
  // clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // core side
  input wire logic deep_sleep_req,
  input wire logic deep_sleep_select,
  input wire logic req_is_wfe,
  input wire logic irq_pending,
  input wire logic event_line_pending,
  input wire logic rtc_alarm_flag,
  input wire logic flash_prog_busy,
  input wire logic apb_busy,
  // wakeup sources
  input wire logic external_event_lines_irq_wake,
  input wire logic external_event_lines_event_wake,
  input wire logic wakeup_pin,
  input wire logic rtc_alarm,
  input wire logic external_reset_pin_n,
  input wire logic independent_watchdog_start,
  input wire logic independent_watchdog_reset,
  input wire logic calib_out_cfg,
  // power, clock and pin controls
  output sspc_pwr_s pwr,
  output sspc_bkd_s bkd,
  output logic independent_watchdog_running,
  output logic backup_write_en,
  output logic wakeup_pin_pulldown,
  output logic keep_calib_pin,
  output logic keep_wakeup_pin,
  output logic sys_reset_req,
  output logic in_stop,
  output logic in_standby
);
  // ==========================================================
  // registers and state
  sspc_state_e state;
  logic [15:0] cnt;
  logic regulator_lowpower_in_stop, powerdown_on_deepsleep, backup_write_unlock, wakeup_pin_enable;
  logic wakeup_received_flag, standby_entered_flag;
  logic [SSPC_CLEAR_WAKEUP_FLAG_CMD_DELAY-1:0] clear_wakeup_flag_cmd_pipe;
  logic mode_stby, mode_lp, mode_wfe;
  logic pin_d, alarm_d;
  logic [15:0] bkdc;
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        old[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return old;
  endfunction

  wire do_wr = aw_held && w_held && !s_bvalid;
  wire [31:0] ctrl_new = merge({23'h0, backup_write_unlock, 4'h0, 2'h0, powerdown_on_deepsleep, regulator_lowpower_in_stop}, w_data, w_strb);
  wire [31:0] stat_new = merge({23'h0, wakeup_pin_enable, 8'h0}, w_data, w_strb);
  wire [31:0] bkdc_new = merge({16'h0, bkdc}, w_data, w_strb);
  wire wr_ctrl = do_wr && aw_addr == SSPC_OFS_CTRL;
  wire wr_stat = do_wr && aw_addr == SSPC_OFS_STAT;
  wire wr_bkdc = do_wr && aw_addr == SSPC_OFS_BKDC;
  wire pin_rise = wakeup_pin && !pin_d && wakeup_pin_enable;
  wire alarm_rise = rtc_alarm && !alarm_d;
  // entry is refused while anything is pending
  // RULE9: pending blocks entry
  wire pend_any = irq_pending || event_line_pending || rtc_alarm_flag;

  // ==========================================================
  // axi write channel: address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= 2'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_awaddr[7:2], 2'h0};
      end
      if (s_wvalid && s_wready) begin
        w_held <= 1'b1;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_bvalid <= 1'b1;
        // unmapped addresses answer slverr
        s_bresp <= (wr_ctrl || wr_stat || wr_bkdc) ? 2'h0 : 2'h2;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end
  assign s_awready = !aw_held && !s_bvalid;
  assign s_wready = !w_held && !s_bvalid;

  // read channel: one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= 2'h0;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp <= 2'h0;
      case ({s_araddr[7:2], 2'h0})
        // RULE19: clear bits read zero
        SSPC_OFS_CTRL: s_rdata <= {23'h0, backup_write_unlock, 6'h0, powerdown_on_deepsleep, regulator_lowpower_in_stop};
        SSPC_OFS_STAT: s_rdata <= {23'h0, wakeup_pin_enable, 6'h0, standby_entered_flag, wakeup_received_flag};
        SSPC_OFS_BKDC: s_rdata <= {16'h0, bkdc};
        default: begin
          s_rdata <= 32'h0000_0000;
          s_rresp <= 2'h2;
        end
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
  assign s_arready = !s_rvalid;

  // ==========================================================
  // control bits; system reset (and standby exit) clears them
  always_ff @(posedge aclk) begin
    if (!aresetn || sys_reset_req) begin
      regulator_lowpower_in_stop <= SSPC_CTRL_RESET[SSPC_CTRL_REGULATOR_LOWPOWER_IN_STOP];
      powerdown_on_deepsleep <= SSPC_CTRL_RESET[SSPC_CTRL_POWERDOWN_ON_DEEPSLEEP];
      backup_write_unlock <= SSPC_CTRL_RESET[SSPC_CTRL_DBP];
      wakeup_pin_enable <= SSPC_STAT_RESET[SSPC_STAT_WAKEUP_PIN_ENABLE];
    end else begin
      if (wr_ctrl) begin
        // RULE22: regulator low-power bit
        regulator_lowpower_in_stop <= ctrl_new[SSPC_CTRL_REGULATOR_LOWPOWER_IN_STOP];
        // RULE21: stop or standby select
        powerdown_on_deepsleep <= ctrl_new[SSPC_CTRL_POWERDOWN_ON_DEEPSLEEP];
        // RULE18: backup write unlock
        backup_write_unlock <= ctrl_new[SSPC_CTRL_DBP];
      end
      if (wr_stat) begin
        wakeup_pin_enable <= stat_new[SSPC_STAT_WAKEUP_PIN_ENABLE];
      end
    end
  end

  // backup domain control copy, kept across system reset
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      bkdc <= 16'h0000;
    end else if (wr_bkdc && backup_write_unlock) begin
      bkdc <= bkdc_new[15:0];
    end
  end

  // edge detectors for wakeup pin and alarm
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_d <= 1'b0;
      alarm_d <= 1'b0;
    end else begin
      // enabling with pin already high counts as an edge
      pin_d <= wakeup_pin && wakeup_pin_enable;
      alarm_d <= rtc_alarm;
    end
  end

  // ==========================================================
  // wakeup flag: set wins over the delayed clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wakeup_received_flag <= 1'b0;
      clear_wakeup_flag_cmd_pipe <= '0;
    end else begin
      clear_wakeup_flag_cmd_pipe <= {clear_wakeup_flag_cmd_pipe[SSPC_CLEAR_WAKEUP_FLAG_CMD_DELAY-2:0], wr_ctrl && w_data[SSPC_CTRL_CLEAR_WAKEUP_FLAG_CMD] && w_strb[0]};
      // RULE23: pin or alarm sets flag
      if (pin_rise || alarm_rise) begin
        wakeup_received_flag <= 1'b1;
      // RULE20: delayed clear
      end else if (clear_wakeup_flag_cmd_pipe[SSPC_CLEAR_WAKEUP_FLAG_CMD_DELAY-1]) begin
        wakeup_received_flag <= 1'b0;
      end
    end
  end

  // standby flag: only power-on reset or the command clears it
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      standby_entered_flag <= 1'b0;
    // RULE14: report standby after wake
    end else if (state == SSPC_STBY) begin
      standby_entered_flag <= 1'b1;
    // RULE25: command clear
    end else if (wr_ctrl && w_data[SSPC_CTRL_CLEAR_STANDBY_FLAG_CMD] && w_strb[0]) begin
      standby_entered_flag <= 1'b0;
    end
  end

  // watchdog run latch: only power-on reset stops it
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      independent_watchdog_running <= 1'b0;
    // RULE5: watchdog persistence
    end else if (independent_watchdog_start) begin
      independent_watchdog_running <= 1'b1;
    end
  end

  // ==========================================================
  // low-power state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SSPC_RUN;
      cnt <= 16'h0;
      mode_stby <= 1'b0;
      mode_lp <= 1'b0;
      mode_wfe <= 1'b0;
      sys_reset_req <= 1'b0;
    end else begin
      case (state)
        SSPC_RUN: begin
          sys_reset_req <= 1'b0;
          // RULE26: sample mode bits with request
          // RULE8: deep-sleep entry
          if (deep_sleep_req && deep_sleep_select && !pend_any) begin
            mode_stby <= powerdown_on_deepsleep;
            mode_lp <= regulator_lowpower_in_stop;
            mode_wfe <= req_is_wfe;
            // RULE15: standby needs clear wakeup flag
            if (!(powerdown_on_deepsleep && wakeup_received_flag)) begin
              state <= SSPC_STOP_WAIT;
            end
          end
        end
        SSPC_STOP_WAIT: begin
          // RULE3: wait flash
          // RULE4: wait bus
          if (!flash_prog_busy && !apb_busy) begin
            state <= mode_stby ? SSPC_STBY : SSPC_STOP;
          end
        end
        SSPC_STOP: begin
          // RULE10: wake source by entry kind
          if (mode_wfe ? external_event_lines_event_wake : external_event_lines_irq_wake) begin
            state <= SSPC_STOP_WAKE;
            cnt <= 16'(HSI_START_CYC);
          end
        end
        SSPC_STOP_WAKE: begin
          // RULE7: wait internal rc start-up
          if (cnt <= 16'h1) begin
            state <= SSPC_RUN;
          end
          cnt <= cnt - 16'h1;
        end
        SSPC_STBY: begin
          // RULE12: standby wake sources
          if (!external_reset_pin_n || independent_watchdog_reset || alarm_rise || pin_rise) begin
            state <= SSPC_STBY_RST;
            cnt <= 16'(RESET_PHASE_CYC);
            // RULE13: reset phase on wake
            sys_reset_req <= 1'b1;
          end
        end
        SSPC_STBY_RST: begin
          if (cnt <= 16'h1) begin
            state <= SSPC_RUN;
          end
          cnt <= cnt - 16'h1;
        end
        default: state <= SSPC_RUN;
      endcase
    end
  end

  // ==========================================================
  // registered power, clock and pin controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr <= '{core_clk_en: 1'b1, pll_en: 1'b1, hsi_en: 1'b1, hse_en: 1'b1, reg_on: 1'b1,
               reg_lowpower: 1'b0, io_freeze: 1'b0, io_hiz: 1'b0, hsi_sysclk_sel: 1'b0};
      in_stop <= 1'b0;
      in_standby <= 1'b0;
    end else begin
      in_stop <= state == SSPC_STOP;
      in_standby <= state == SSPC_STBY;
      // RULE1: stop clock gating
      // RULE11: standby power off
      pwr.core_clk_en <= !(state == SSPC_STOP || state == SSPC_STBY);
      pwr.pll_en <= !(state == SSPC_STOP || state == SSPC_STBY);
      pwr.hse_en <= !(state == SSPC_STOP || state == SSPC_STBY);
      pwr.hsi_en <= !(state == SSPC_STOP || state == SSPC_STBY);
      pwr.reg_on <= state != SSPC_STBY;
      pwr.reg_lowpower <= state == SSPC_STOP && mode_lp;
      // RULE2: io hold in stop
      pwr.io_freeze <= state == SSPC_STOP;
      // RULE16: io high impedance in standby
      pwr.io_hiz <= state == SSPC_STBY;
      // RULE7: internal rc after stop
      if (state == SSPC_STOP_WAKE) begin
        pwr.hsi_sysclk_sel <= 1'b1;
      end else if (state == SSPC_STBY_RST) begin
        pwr.hsi_sysclk_sel <= 1'b0;
      end
    end
  end

  // backup-side outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bkd <= '0;
      backup_write_en <= 1'b0;
      wakeup_pin_pulldown <= 1'b0;
      keep_calib_pin <= 1'b0;
      keep_wakeup_pin <= 1'b0;
    end else begin
      // RULE6: rtc and lse follow control
      bkd.rtc_en <= bkdc[SSPC_BKDC_RTC_CLOCK_ENABLE];
      bkd.lse_on <= bkdc[SSPC_BKDC_LOW_SPEED_CRYSTAL_ON];
      // RULE17: rtc clock source
      bkd.rtc_src <= bkdc[SSPC_BKDC_RTCSEL +: 2];
      backup_write_en <= backup_write_unlock;
      // RULE24: wakeup pin pull-down
      wakeup_pin_pulldown <= wakeup_pin_enable;
      keep_calib_pin <= calib_out_cfg;
      keep_wakeup_pin <= wakeup_pin_enable;
    end
  end

  // ==========================================================
  // checks
  property p_stop_clk;
    @(posedge aclk) disable iff (!aresetn) (state == SSPC_STOP) |=> !pwr.core_clk_en && !pwr.hsi_en;
  endproperty
  stop_clock_a: assert property (p_stop_clk) else $error("clocks running in stop"); // RULE1
  stop_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == SSPC_STOP) |=> pwr.io_freeze) else $error("io not frozen in stop"); // RULE2
  busy_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == SSPC_STOP_WAIT && (flash_prog_busy || apb_busy)) |=> state == SSPC_STOP_WAIT)
    else $error("entry while busy"); // RULE3
  pend_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == SSPC_RUN && pend_any) |=> state == SSPC_RUN) else $error("entry while pending"); // RULE9
  stby_power_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == SSPC_STBY) |=> !pwr.reg_on && pwr.io_hiz) else $error("standby power wrong"); // RULE11
  wuf_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_ctrl && w_data[SSPC_CTRL_CLEAR_WAKEUP_FLAG_CMD] && w_strb[0] && wakeup_received_flag) ##1 !(pin_rise || alarm_rise)[*3] |-> !wakeup_received_flag)
    else $error("wakeup flag not cleared"); // RULE20
  wuf_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pin_rise || alarm_rise) |=> wakeup_received_flag) else $error("wakeup flag not set"); // RULE23
  stby_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == SSPC_STBY && independent_watchdog_reset) |=> sys_reset_req) else $error("no reset on wake"); // RULE13
  mode_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state != SSPC_RUN) |=> $stable(mode_stby)) else $error("mode changed in sleep"); // RULE26
  stop_cover_c: cover property (@(posedge aclk) disable iff (!aresetn) state == SSPC_STOP_WAKE);
  stby_cover_c: cover property (@(posedge aclk) disable iff (!aresetn) state == SSPC_STBY_RST);
  clear_wakeup_flag_cmd_cover_c: cover property (@(posedge aclk) disable iff (!aresetn) clear_wakeup_flag_cmd_pipe[SSPC_CLEAR_WAKEUP_FLAG_CMD_DELAY-1]);
endmodule
`default_nettype wire

/* testbench/sspc_core_model.sv */
/*
  far-side model: core, interrupt controller and wakeup sources.
  assumes the bench moves its lines just after a rising edge of aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module sspc_core_model (
  // clock
  input wire logic aclk,
  // core side
  output logic deep_sleep_req,
  output logic deep_sleep_select,
  output logic req_is_wfe,
  output logic irq_pending,
  output logic event_line_pending,
  output logic rtc_alarm_flag,
  output logic flash_prog_busy,
  output logic apb_busy,
  // wakeup sources and resets
  output logic external_event_lines_irq_wake,
  output logic external_event_lines_event_wake,
  output logic wakeup_pin,
  output logic rtc_alarm,
  output logic external_reset_pin_n,
  output logic independent_watchdog_start,
  output logic independent_watchdog_reset,
  output logic por_n
);
  // ==========================================================
  // quiet levels; power-on reset held with the system reset
  initial begin
    {deep_sleep_req, deep_sleep_select, req_is_wfe, irq_pending} = 4'h0;
    {event_line_pending, rtc_alarm_flag, flash_prog_busy, apb_busy} = 4'h0;
    {external_event_lines_irq_wake, external_event_lines_event_wake, wakeup_pin, rtc_alarm} = 4'h0;
    {independent_watchdog_start, independent_watchdog_reset, por_n} = 3'h0;
    external_reset_pin_n = 1'b1;
  end
  // ==========================================================
  // select level settles with the one-cycle request
  task automatic sleep(input logic wait_for_event_instr);
    @(posedge aclk);
    deep_sleep_select <= 1'b1;
    req_is_wfe <= wait_for_event_instr;
    deep_sleep_req <= 1'b1;
    @(posedge aclk);
    deep_sleep_req <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* testbench/test_stop_standby_power_controller.sv */
/*
  bench for the power controller: axi4-lite tasks, stop and standby runs.
  assumes small start-up counts; the far side is sspc_core_model.
*/
`timescale 1ns/1ps
`default_nettype none
module test_stop_standby_power_controller;
  import sspc_pkg::*;
  logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [1:0] s_bresp, s_rresp;
  logic deep_sleep_req, deep_sleep_select, req_is_wfe, irq_pending, event_line_pending;
  logic rtc_alarm_flag, flash_prog_busy, apb_busy, external_event_lines_irq_wake, external_event_lines_event_wake;
  logic wakeup_pin, rtc_alarm, external_reset_pin_n, independent_watchdog_start, independent_watchdog_reset, por_n;
  logic independent_watchdog_running, backup_write_en, wakeup_pin_pulldown, keep_calib_pin;
  logic keep_wakeup_pin, sys_reset_req, in_stop, in_standby;
  logic [3:0] s_wstrb;
  logic calib_out_cfg;
  sspc_pwr_s pwr;
  sspc_bkd_s bkd;
  int failures, compares, cyc;
  // ==========================================================
  // design and far side, short start-up counts keep runs brief
  sspc_ctrl #(.HSI_START_CYC(4), .RESET_PHASE_CYC(4)) u_dut (
    .aclk, .aresetn, .por_n, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .deep_sleep_req,
    .deep_sleep_select, .req_is_wfe, .irq_pending, .event_line_pending, .rtc_alarm_flag,
    .flash_prog_busy, .apb_busy, .external_event_lines_irq_wake, .external_event_lines_event_wake, .wakeup_pin, .rtc_alarm,
    .external_reset_pin_n, .independent_watchdog_start, .independent_watchdog_reset, .calib_out_cfg, .pwr, .bkd,
    .independent_watchdog_running, .backup_write_en, .wakeup_pin_pulldown, .keep_calib_pin,
    .keep_wakeup_pin, .sys_reset_req, .in_stop, .in_standby);
  sspc_core_model u_core (
    .aclk, .deep_sleep_req, .deep_sleep_select, .req_is_wfe, .irq_pending,
    .event_line_pending, .rtc_alarm_flag, .flash_prog_busy, .apb_busy, .external_event_lines_irq_wake,
    .external_event_lines_event_wake, .wakeup_pin, .rtc_alarm, .external_reset_pin_n, .independent_watchdog_start,
    .independent_watchdog_reset, .por_n);
  // ==========================================================
  // clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end
  // ==========================================================
  // helpers
  task automatic give_verdict;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // both halves offered together, each released at its own edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    {s_awvalid, s_wvalid, s_bready} <= 3'b111;
    while (!(ta && tw)) begin
      @(posedge aclk);
      ta = ta | (s_awready === 1'b1);
      tw = tw | (s_wready === 1'b1);
      s_awvalid <= !ta;
      s_wvalid <= !tw;
    end
    do @(posedge aclk); while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
    chk({30'h0, s_bresp}, 32'h0);
  endtask
  // read, mask and compare data and response
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] re);
    @(posedge aclk);
    s_araddr <= a;
    {s_arvalid, s_rready} <= 2'b11;
    do @(posedge aclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    do @(posedge aclk); while (s_rvalid !== 1'b1);
    s_rready <= 1'b0;
    chk(s_rdata & m, e);
    chk({30'h0, s_rresp}, {30'h0, re});
  endtask
  function automatic logic sg(input int s);
    case (s)
      0: return in_stop;
      1: return in_standby;
      2: return sys_reset_req;
      default: return backup_write_en;
    endcase
  endfunction
  // bounded wait for a status level, then compare it
  task automatic wt(input int s, input logic v);
    int n;
    n = 0;
    while (sg(s) !== v && n < 50) begin
      @(posedge aclk);
      n++;
    end
    chk({31'h0, sg(s)}, {31'h0, v});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    aresetn = 1'b0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h0;
    {s_awaddr, s_araddr, s_wdata} = 48'h0;
    s_wstrb = 4'hf;
    calib_out_cfg = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    u_core.por_n <= 1'b1;
    rc(SSPC_OFS_CTRL, 32'hffffffff, SSPC_CTRL_RESET, 2'b00);
    rc(SSPC_OFS_STAT, 32'hffffffff, SSPC_STAT_RESET, 2'b00);
    rc(8'h40, 32'hffffffff, 32'h0, 2'b10);
    wr(SSPC_OFS_CTRL, 32'h0000010d);
    rc(SSPC_OFS_CTRL, 32'h0000010f, 32'h00000101, 2'b00);
    wt(3, 1'b1);
    // each pending source must cancel the request
    for (int i = 0; i < 3; i++) begin
      {u_core.irq_pending, u_core.event_line_pending, u_core.rtc_alarm_flag} <= 3'(1 << i);
      u_core.sleep(1'b0);
      repeat (8) @(posedge aclk);
      wt(0, 1'b0);
    end
    {u_core.irq_pending, u_core.event_line_pending, u_core.rtc_alarm_flag} <= 3'h0;
    // flash then bus busy delays entry; wfi then wfe exit
    for (int i = 0; i < 2; i++) begin
      {u_core.flash_prog_busy, u_core.apb_busy} <= 2'b10 >> i;
      u_core.sleep(i[0]);
      repeat (10) @(posedge aclk);
      wt(0, 1'b0);
      {u_core.flash_prog_busy, u_core.apb_busy} <= 2'b00;
      wt(0, 1'b1);
      chk({23'h0, pwr} & 32'h1fe, 32'h01c);
      {u_core.external_event_lines_irq_wake, u_core.external_event_lines_event_wake} <= 2'b10 >> i;
      wt(0, 1'b0);
      chk({31'h0, pwr.hsi_sysclk_sel}, 32'h1);
      {u_core.external_event_lines_irq_wake, u_core.external_event_lines_event_wake} <= 2'b00;
      // let the rc start-up count run out before the next request
      repeat (8) @(posedge aclk);
    end
    // standby with the wakeup pin armed
    calib_out_cfg <= 1'b1;
    wr(SSPC_OFS_STAT, 32'h00000100);
    wr(SSPC_OFS_CTRL, 32'h00000102);
    u_core.sleep(1'b0);
    wt(1, 1'b1);
    chk({23'h0, pwr} & 32'h1f2, 32'h002);
    chk({29'h0, keep_wakeup_pin, keep_calib_pin, wakeup_pin_pulldown}, 32'h7);
    u_core.wakeup_pin <= 1'b1;
    wt(2, 1'b1);
    wt(2, 1'b0);
    wt(1, 1'b0);
    u_core.wakeup_pin <= 1'b0;
    rc(SSPC_OFS_CTRL, 32'hffffffff, 32'h0, 2'b00);
    rc(SSPC_OFS_STAT, 32'h3, 32'h3, 2'b00);
    // a raised wakeup flag refuses standby
    wr(SSPC_OFS_CTRL, 32'h00000002);
    u_core.sleep(1'b0);
    repeat (8) @(posedge aclk);
    wt(1, 1'b0);
    wt(0, 1'b0);
    wr(SSPC_OFS_CTRL, 32'h00000006);
    rc(SSPC_OFS_STAT, 32'h3, 32'h2, 2'b00);
    wr(SSPC_OFS_CTRL, 32'h00000008);
    rc(SSPC_OFS_STAT, 32'h3, 32'h0, 2'b00);
    // only byte lane 1 written: unlock bit lands, low-power bit untouched
    s_wstrb <= 4'h2;
    wr(SSPC_OFS_CTRL, 32'h00000101);
    rc(SSPC_OFS_CTRL, 32'hffffffff, 32'h00000100, 2'b00);
    s_wstrb <= 4'hf;
    give_verdict();
  end
endmodule
`default_nettype wire
